// ### logic/adcdm_capture.sv
// adcdm_capture: external capture logic latching both buses, or bus b alone when decimating, on rising output clock edges
// assumes the same core_clk as the converter; buffer decouples a stalling consumer
`timescale 1ns/1ps
module adcdm_capture (
  input  wire logic        core_clk,
  input  wire logic        reset,
  input  wire logic        sync_request,
  input  wire logic        decimate,
  input  wire logic        out_ready,
  output logic             out_valid,
  output logic [21:0]      out_data,
  output logic             dropped,
  adcdm_if.cap             link
);
  // -----------------------------------------------------------------
  // latch on output clock rising edge
  // -----------------------------------------------------------------
  logic        clk_d;
  logic        sync_q;
  logic        in_valid;
  logic        in_ready;
  logic [21:0] in_data;
  assign in_valid = link.half_rate_output_clock & ~clk_d & ~sync_q;
  // decimation keeps only bus b and zeros bus a
  assign in_data  = decimate ? {11'h000, link.ovr_b, link.bus_b}
                             : {link.ovr_a, link.bus_a, link.ovr_b, link.bus_b};

  always_ff @(posedge core_clk) begin
    if (reset) begin
      clk_d   <= 1'b0;
      sync_q  <= 1'b0;
      dropped <= 1'b0;
    end else begin
      clk_d   <= link.half_rate_output_clock;
      sync_q  <= sync_request;
      dropped <= in_valid & ~in_ready;
    end
  end
  assign link.sample_alignment_input = sync_q;

  // -----------------------------------------------------------------
  // two entry buffer
  // -----------------------------------------------------------------
  logic [21:0] mem [adcdm_pkg::BUF_DEPTH];
  logic        wr_ptr;
  logic        rd_ptr;
  logic [1:0]  count;
  logic        push;
  logic        pop;
  logic [1:0]  next_count;
  // out_valid from a flop means the head is shown one cycle after arrival
  assign in_ready   = (count != 2'h2);
  assign push       = in_valid & in_ready;
  assign pop        = out_valid & out_ready;
  assign next_count = count + {1'b0, push} - {1'b0, pop};

  always_ff @(posedge core_clk) begin
    if (reset) begin
      wr_ptr    <= 1'b0;
      rd_ptr    <= 1'b0;
      count     <= 2'h0;
      out_valid <= 1'b0;
      out_data  <= 22'h00_0000;
    end else begin
      if (push) begin
        mem[wr_ptr] <= in_data;
        wr_ptr      <= ~wr_ptr;
      end
      if (pop) begin
        rd_ptr <= ~rd_ptr;
      end
      count     <= next_count;
      out_valid <= 1'b0;
      if (next_count != 2'h0) begin
        out_valid <= 1'b1;
        out_data  <= (pop ? (count == 2'h2 ? mem[~rd_ptr] : in_data) : mem[rd_ptr]);
        if (count == 2'h0 || (count == 2'h1 && pop)) begin
          out_data <= in_data;
        end
      end
    end
  end
endmodule

// ### logic/adcdm_device.sv
// adcdm_device: converter output stage, demux to two buses at half rate
// assumes raw codes arrive one per core_clk, synchronous; core_clk is the sample clock
//
// Functional notes
// - output clock is sample clock halved, complementary
// - interleaved latency is six cycles
// - parallel mode delays bus a to seven
// - alignment high freezes buses and clock
// - alignment fall: sample at edge N to b
// - sample N+1 goes to bus a
// - other converter's clock may drive alignment
// - source keeps sample rate at least 100 MSPS; the testbench clock runs at 25 MSPS
// - capture may latch one bus to decimate
// - slow clocks keep high phase under 5 ns; the testbench clock stays high for 20 ns
// - offset binary or twos complement, overrange flag
`timescale 1ns/1ps
module adcdm_device (
  input  wire logic       core_clk,
  input  wire logic       reset,
  input  wire logic [9:0] raw_code,
  input  wire logic       raw_over,
  input  wire logic       raw_under,
  input  wire logic       output_format_select,
  input  wire logic       parallel_mode,
  adcdm_if.dev            link
);
  // -----------------------------------------------------------------
  // coding
  // -----------------------------------------------------------------
  logic [9:0] clipped;
  logic [9:0] coded;
  logic       ovr_now;
  assign clipped = raw_under ? 10'h000 : (raw_over ? adcdm_pkg::FULL_SCALE : raw_code);
  // twos complement is offset binary with the msb flipped
  assign coded   = output_format_select ? (clipped ^ adcdm_pkg::MSB_FLIP) : clipped;
  assign ovr_now = raw_over | raw_under;

  // -----------------------------------------------------------------
  // pipeline and phase
  // -----------------------------------------------------------------
  logic [10:0] pipe [adcdm_pkg::PIPE_DEPTH];
  logic        phase;
  logic        sync_d;
  logic        hold;
  logic        next_phase;
  logic        tap_a_en;
  logic        tap_b_en;
  logic        clk_rise;
  logic        clk_fall;
  logic [10:0] tap6;
  logic [10:0] tap7;
  logic        clk_out;
  logic        clk_out_n;

  assign hold = link.sample_alignment_input;
  // after a release, the first edge is sample n, bound for bus b
  assign next_phase = (sync_d & ~hold) ? 1'b0 : ~phase;
  // pipe[k] holds the sample taken k+1 edges back; the bus flop adds the last edge
  assign tap6 = pipe[adcdm_pkg::LAT_INTERLEAVE - 1];
  assign tap7 = pipe[adcdm_pkg::LAT_PARALLEL_A - 1];
  // buses follow the output clock itself: stale words left in a frozen pipe
  // never move off an edge when a release restarts the phase
  assign clk_rise = ~next_phase & ~clk_out;
  assign clk_fall = next_phase & clk_out;
  assign tap_b_en = clk_rise;
  // parallel mode: bus a moves on the rising clock with bus b, one cycle later
  assign tap_a_en = parallel_mode ? clk_rise : clk_fall;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      phase  <= 1'b1;
      sync_d <= 1'b0;
    end else begin
      sync_d <= hold;
      if (!hold) begin
        phase <= next_phase;
      end
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < adcdm_pkg::PIPE_DEPTH; gi++) begin : g_pipe
      if (gi == 0) begin : g_head
        always_ff @(posedge core_clk) begin
          if (reset) begin
            pipe[gi] <= 11'h000;
          end else if (!hold) begin // sampling stops while aligning
            pipe[gi] <= {ovr_now, coded};
          end
        end
      end else begin : g_tail
        always_ff @(posedge core_clk) begin
          if (reset) begin
            pipe[gi] <= 11'h000;
          end else if (!hold) begin
            pipe[gi] <= pipe[gi-1];
          end
        end
      end
    end
  endgenerate

  // -----------------------------------------------------------------
  // outputs
  // -----------------------------------------------------------------
  logic [9:0]  a_word;
  logic        a_ovr;
  logic [9:0]  b_word;
  logic        b_ovr;
  logic [10:0] a_src;
  assign a_src = parallel_mode ? tap7 : tap6;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      clk_out   <= 1'b0;
      clk_out_n <= 1'b1;
    end else if (!hold) begin
      clk_out   <= ~next_phase; // divide by two, realigned on sync
      clk_out_n <= next_phase;  // own flop keeps the pair free of gate skew
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      b_word <= adcdm_pkg::MIDSCALE_BIN;
      b_ovr  <= 1'b0;
    end else if (!hold && tap_b_en) begin
      {b_ovr, b_word} <= tap6; // six cycles
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      a_word <= adcdm_pkg::MIDSCALE_BIN;
      a_ovr  <= 1'b0;
    end else if (!hold && tap_a_en) begin
      {a_ovr, a_word} <= a_src; // six or seven cycles
    end
  end

  assign link.half_rate_output_clock   = clk_out;
  assign link.half_rate_output_clock_n = clk_out_n;
  assign link.bus_a = a_word;
  assign link.ovr_a = a_ovr;
  assign link.bus_b = b_word;
  assign link.ovr_b = b_ovr;
endmodule

// ### logic/adcdm_if.sv
// adcdm_if: pins between the converter output stage and capture logic
// assumes one shared clock; no tristate pins
`timescale 1ns/1ps
interface adcdm_if;
  logic       half_rate_output_clock;
  logic       half_rate_output_clock_n;
  logic [9:0] bus_a;
  logic       ovr_a;
  logic [9:0] bus_b;
  logic       ovr_b;
  logic       sample_alignment_input;
  modport dev (
    output half_rate_output_clock,
    output half_rate_output_clock_n,
    output bus_a,
    output ovr_a,
    output bus_b,
    output ovr_b,
    input  sample_alignment_input
  );
  modport cap (
    input  half_rate_output_clock,
    input  half_rate_output_clock_n,
    input  bus_a,
    input  ovr_a,
    input  bus_b,
    input  ovr_b,
    output sample_alignment_input
  );
endinterface

// ### logic/adcdm_pkg.sv
// adcdm_pkg: shared constants for the demultiplexed converter output timing
// assumes both ends run on one core_clk standing in for the sample clock
package adcdm_pkg;
  localparam int          SAMPLE_W       = 10;
  localparam int          LAT_INTERLEAVE = 6;
  localparam int          LAT_PARALLEL_A = 7;
  localparam int          PIPE_DEPTH     = 8;
  localparam int          BUF_DEPTH      = 2;
  localparam logic [9:0]  MIDSCALE_BIN   = 10'h200;
  localparam logic [9:0]  MIDSCALE_TWOS  = 10'h000;
  localparam logic [9:0]  FULL_SCALE     = 10'h3ff;
  localparam logic [9:0]  MSB_FLIP       = 10'h200;
  localparam real         CLK_PERIOD_NS  = 40.0;
  localparam real         MIN_RATE_MSPS  = 100.0;
  localparam real         MAX_HIGH_NS    = 5.0;
  localparam int          MAX_HIGH_CYC   = 1;
endpackage

// ### test/adc_demux_output_sync_tb.sv
// adc_demux_output_sync_tb: both ends joined, driven from their user sides
// assumes a 25 MHz core_clk; raw codes count up so each sample is traceable
`timescale 1ns/1ps
module adc_demux_output_sync_tb;
  logic        core_clk = 0, reset = 1, raw_over = 0, raw_under = 0;
  logic        output_format_select = 0, parallel_mode = 0, sync_request = 0;
  logic        decimate = 0, out_ready = 1, out_valid, dropped, drop_seen = 0;
  logic [9:0]  raw_code = 10'h000;
  logic [21:0] out_data;
  int          fail_count = 0, n_checks = 0;
  adcdm_if link ();
  adcdm_device i_adcdm_device (.core_clk, .reset, .raw_code, .raw_over, .raw_under,
    .output_format_select, .parallel_mode, .link);
  adcdm_capture i_adcdm_capture (.core_clk, .reset, .sync_request, .decimate, .out_ready,
    .out_valid, .out_data, .dropped, .link);
  adcdm_properties i_adcdm_properties (.core_clk, .reset, .bus_a(link.bus_a),
    .half_rate_output_clock(link.half_rate_output_clock), .ovr_a(link.ovr_a),
    .half_rate_output_clock_n(link.half_rate_output_clock_n), .bus_b(link.bus_b),
    .ovr_b(link.ovr_b), .sample_alignment_input(link.sample_alignment_input));
  // stands in for the sample clock; rate and high-phase limits are analog
  always #20 core_clk = ~core_clk;
  always @(negedge core_clk) raw_code <= raw_code + 10'h001;
  always @(posedge core_clk) if (dropped === 1'b1) drop_seen <= 1'b1;
  task automatic check(input logic [9:0] seen, input logic [9:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // ----
  // scenarios
  // ----
  task automatic sync_chk(input logic fmt, input logic par, input logic ov, input logic un);
    logic [9:0] n;
    logic [9:0] flip;
    @(negedge core_clk);
    sync_request = 1'b1;
    flip = fmt ? 10'h200 : 10'h000;
    repeat (2) @(negedge core_clk);
    // modes and flags change only while the outputs are frozen
    {output_format_select, parallel_mode, raw_over, raw_under} = {fmt, par, ov, un};
    @(negedge core_clk);
    sync_request = 1'b0;
    // first edge that sees alignment low takes sample n
    @(posedge core_clk iff link.sample_alignment_input === 1'b0);
    n = ov ? 10'h3ff : un ? 10'h000 : raw_code;
    repeat (6) @(posedge core_clk);
    #1 check(link.bus_b, n ^ flip);
    check({9'h000, link.ovr_b}, {9'h000, ov | un});
    repeat (par ? 2 : 1) @(posedge core_clk);
    #1 check(link.bus_a, ((ov | un) ? n : n + 10'h001) ^ flip);
    check({9'h000, link.ovr_a}, {9'h000, ov | un});
    // both modes capture n+1 on bus a and n+2 on bus b at the next rising clock
    repeat (par ? 1 : 2) @(posedge core_clk);
    #1 check(out_data[20:11], ((ov | un) ? n : n + 10'h001) ^ flip);
    check(out_data[9:0], ((ov | un) ? n : n + 10'h002) ^ flip);
    check({9'h000, out_valid}, 10'h001);
  endtask
  task automatic t_freeze;
    logic [9:0] a;
    logic [9:0] b;
    // counting codes, so a broken freeze would show on the buses
    @(negedge core_clk) {raw_over, raw_under} = 2'b00;
    repeat (8) @(negedge core_clk);
    sync_request = 1'b1;
    repeat (3) @(negedge core_clk);
    a = link.bus_a;
    b = link.bus_b;
    repeat (5) @(negedge core_clk);
    check(link.bus_a, a);
    check(link.bus_b, b);
    sync_request = 1'b0;
  endtask
  task automatic t_stall;
    // consumer stalls long enough to overrun the two-entry buffer
    @(negedge core_clk) decimate = 1'b1;
    // words latched before decimation drain before the stall begins
    repeat (2) @(negedge core_clk);
    out_ready = 1'b0;
    repeat (12) @(negedge core_clk);
    check({9'h000, out_valid}, 10'h001);
    check({9'h000, drop_seen}, 10'h001);
    check(out_data[20:11], 10'h000);
    {out_ready, decimate} = 2'b10;
    repeat (4) @(negedge core_clk);
  endtask
  initial begin
    repeat (3) @(negedge core_clk);
    reset = 1'b0;
    for (int f = 0; f < 2; f++) sync_chk(f[0], 1'b0, 1'b0, 1'b0);
    sync_chk(1'b0, 1'b1, 1'b0, 1'b0);
    sync_chk(1'b1, 1'b0, 1'b1, 1'b0);
    sync_chk(1'b1, 1'b1, 1'b0, 1'b1);
    t_freeze;
    t_stall;
    end_of_test;
  end
  initial begin
    #100000;
    fail_count++;
    end_of_test;
  end
endmodule

// ### test/adcdm_properties.sv
// adcdm_properties: timing checks on the converter-to-capture link
// assumes one core_clk domain and a synchronous active-high reset
`timescale 1ns/1ps
module adcdm_properties (
  input wire logic       core_clk,
  input wire logic       reset,
  input wire logic       half_rate_output_clock,
  input wire logic       half_rate_output_clock_n,
  input wire logic [9:0] bus_a,
  input wire logic       ovr_a,
  input wire logic [9:0] bus_b,
  input wire logic       ovr_b,
  input wire logic       sample_alignment_input
);
  wire dclk = half_rate_output_clock;
  wire algn = sample_alignment_input;
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  // ----
  // properties
  // ----
  sequence align_fall; $fell(algn); endsequence
  // launched at the sixth edge, seen one edge later through the output flops
  sequence b_launch; ##7 $rose(dclk); endsequence
  AST_CLK_PAIR: assert property (half_rate_output_clock_n == !dclk)
    else $error("output clock pair not complementary");
  // the release edge may stretch one phase while the divider realigns
  AST_CLK_DIV: assert property (!algn && !$past(algn) |=> $changed(dclk))
    else $error("output clock missed a toggle");
  AST_FREEZE: assert property (algn |=> $stable(dclk) && $stable(bus_a) && $stable(bus_b))
    else $error("outputs moved while frozen");
  AST_B_RISE: assert property ($changed(bus_b) || $changed(ovr_b) |-> $rose(dclk))
    else $error("bus b moved off the rising output clock");
  AST_A_EDGE: assert property ($changed(bus_a) || $changed(ovr_a) |-> $changed(dclk))
    else $error("bus a moved off an output clock edge");
  AST_B_HOLD: assert property ($changed(bus_b) |=> $stable(bus_b))
    else $error("bus b word held one cycle only");
  AST_A_HOLD: assert property ($changed(bus_a) |=> $stable(bus_a))
    else $error("bus a word held one cycle only");
  AST_SYNC_B: assert property (align_fall |-> b_launch)
    else $error("aligned sample not launched on bus b after six cycles");
  AST_RST_MID: assert property ($fell(reset) |-> bus_a == 10'h200 && bus_b == 10'h200)
    else $error("buses not at midscale out of reset");
endmodule
